// *** src/pmrc_consts.svh ***
// Constants for the power-mode and reset controller
`ifndef PMRC_CONSTS_SVH
`define PMRC_CONSTS_SVH

// Register byte offsets
`define PMRC_OFS_CTRL 12'h000
`define PMRC_OFS_CLKGATE 12'h004
`define PMRC_OFS_WAKEEN 12'h008
`define PMRC_OFS_STATUS 12'h00c
`define PMRC_OFS_BOOT 12'h010
// Control field positions
`define PMRC_CTRL_MODE_LSB 0
`define PMRC_CTRL_LOCK_BIT 2
`define PMRC_CTRL_WDIRC_BIT 3
`define PMRC_CTRL_WATCHDOG_OSC_BIT 4
`define PMRC_CTRL_BODON_BIT 5
`define PMRC_CTRL_BODRST_BIT 6
`define PMRC_CTRL_BODLVL_BIT 7
`define PMRC_CTRL_SYSCLK_BIT 8
// Reset values
`define PMRC_CTRL_RST 32'h0000_0020
`define PMRC_CLKGATE_RST 32'hffff_ffff
`define PMRC_WAKEEN_RST 32'h0000_0000
`define PMRC_BOOT_ADDR 32'h0000_0000
// Timing
`define PMRC_CLK_MHZ 50
`define PMRC_RST_MIN_NS 50
`define PMRC_RST_MIN_CYC ((`PMRC_RST_MIN_NS * `PMRC_CLK_MHZ + 999) / 1000)
`define PMRC_RST_STRETCH 4

`endif

// *** src/pmrc_pkg.sv ***
// Types for the power-mode and reset controller
`default_nettype none
package pmrc_pkg;
	typedef enum logic [2:0] {
		PMRC_ACTIVE = 3'b000,
		PMRC_SLEEP = 3'b001,
		PMRC_DSLEEP = 3'b010,
		PMRC_PDOWN = 3'b011,
		PMRC_DPD = 3'b100
	} pmrc_state_t;

	typedef struct packed {
		logic core_clk_en;
		logic irc_en;
		logic irc_out_en;
		logic watchdog_osc_en;
		logic sysosc_en;
		logic analog_en;
		logic flash_on;
		logic flash_standby;
		logic bod_en;
		logic chip_power;
	} pmrc_power_t;

	typedef struct packed {
		logic [7:0] gpio;
		logic wdt;
		logic usb;
		logic rtc;
		logic [3:0] uart;
	} pmrc_wake_t;
endpackage : pmrc_pkg
`default_nettype wire

// *** src/pmrc_top.sv ***
// Power-mode and reset controller with an AXI4-Lite register slave
// What this block does
// - Software gates each peripheral clock individually
// - Sleep gates core clock; wake re-enables it
// - Sleep halts core until reset or interrupt
// - Deep-sleep stops peripheral clocks, keeps internal RC
// - Deep-sleep RC output only if watchdog clock
// - Deep-sleep: analogue off, flash standby, options
// - Deep-sleep wakes on listed sources
// - Serial wake needs 32k, sync or CTS
// - Power-down: all off except selected watchdog osc and enabled brownout detector
// - Power-down wakes on same sources
// - Deep power-down wakes by wake pin, RTC
// - Lock bit refuses deep power-down entry
// - Chip reset merges pin, watchdog, POR, brownout
// - Any reset starts RC and flash init
// - After reset core fetches at address 0
// - Internal reset state drives reset status pin
// - Reset pin pulse of 50 ns resets, wakes
// - Reset pin ignored in deep power-down
// - Brownout raises interrupt and status bit
// - Two brownout levels selectable for reset
// - System clock reverts to internal RC on reset
`include "pmrc_consts.svh"
`default_nettype none
module pmrc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Core side
	input wire logic core_sleep_req,
	input wire logic core_irq_pending,
	output logic core_reset_n,
	output logic [31:0] core_boot_addr,
	output logic brownout_irq,
	// Pins and wake sources
	input wire logic reset_pin_n,
	input wire logic deep_wake_pin,
	input wire logic wdt_reset,
	input wire logic por_n,
	input wire logic bod_below_irq,
	input wire logic bod_below_rst,
	input wire logic [1:0] bod_below_lvl,
	input wire pmrc_pkg::pmrc_wake_t wake_in,
	input wire logic [3:0] uart_wake_ok,
	input wire logic rtc_wake,
	// Clock and power controls
	output logic [31:0] periph_clk_en,
	output pmrc_pkg::pmrc_power_t power_ctl,
	output logic sysclk_sel_rc,
	output logic reset_state_out
);
	// =====================================================
	// Input synchronisers
	logic [1:0] s1_q, s2_q;
	logic [17:0] w1_q, w2_q;
	pmrc_pkg::pmrc_wake_t wake_s;
	logic rpin_s, dwake_s, bod_irq_s;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			w1_q <= 18'h00000;
			w2_q <= 18'h00000;
		end else begin
			s1_q <= {reset_pin_n, deep_wake_pin};
			s2_q <= s1_q;
			w1_q <= {wake_in, bod_below_irq, bod_below_lvl};
			w2_q <= w1_q;
		end
	end
	assign rpin_s = s2_q[1];
	assign dwake_s = s2_q[0];
	assign wake_s = pmrc_pkg::pmrc_wake_t'(w2_q[17:3]);
	logic [1:0] bod_lvl_s;
	assign bod_irq_s = w2_q[2];
	assign bod_lvl_s = w2_q[1:0];

	// =====================================================
	// Registers
	logic [31:0] ctrl_q, clkgate_q, wakeen_q;
	logic [1:0] mode_sel;
	logic lock, wd_irc, wd_osc, bod_on, bod_rst_en, bod_lvl;
	assign mode_sel = ctrl_q[`PMRC_CTRL_MODE_LSB +: 2];
	assign lock = ctrl_q[`PMRC_CTRL_LOCK_BIT];
	assign wd_irc = ctrl_q[`PMRC_CTRL_WDIRC_BIT];
	assign wd_osc = ctrl_q[`PMRC_CTRL_WATCHDOG_OSC_BIT];
	assign bod_on = ctrl_q[`PMRC_CTRL_BODON_BIT];
	assign bod_rst_en = ctrl_q[`PMRC_CTRL_BODRST_BIT];
	assign bod_lvl = ctrl_q[`PMRC_CTRL_BODLVL_BIT];

	// =====================================================
	// Reset merge and stretch
	logic [3:0] rlow_q;
	logic [2:0] stretch_q;
	logic chip_rst_q, pin_rst, bod_rst, any_rst, dpd_exit;
	pmrc_pkg::pmrc_state_t st_q;
	// Pin must be low for the minimum pulse; a shorter glitch is ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rlow_q <= 4'h0;
		else if (rpin_s || st_q == pmrc_pkg::PMRC_DPD)
			rlow_q <= 4'h0;
		else if (rlow_q != 4'hf)
			rlow_q <= rlow_q + 4'h1;
	end
	assign pin_rst = 32'(rlow_q) >= `PMRC_RST_MIN_CYC;
	assign bod_rst = bod_rst_en && bod_on && bod_lvl_s[bod_lvl];
	assign any_rst = pin_rst || wdt_reset || !por_n || bod_rst;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stretch_q <= 3'h7;
			chip_rst_q <= 1'b1;
		end else if (any_rst || dpd_exit) begin
			stretch_q <= 3'(`PMRC_RST_STRETCH);
			chip_rst_q <= 1'b1;
		end else if (stretch_q != 3'h0) begin
			stretch_q <= stretch_q - 3'h1;
			chip_rst_q <= 1'b1;
		end else
			chip_rst_q <= 1'b0;
	end

	// =====================================================
	// Mode sequencer
	logic wake_any, wake_dpd, sleep_wake;
	logic [14:0] wake_mask;
	assign wake_mask = wakeen_q[14:0] & {8'hff, 3'h7, uart_wake_ok};
	assign wake_any = |(wake_s & wake_mask);
	assign wake_dpd = !dwake_s || rtc_wake;
	assign dpd_exit = st_q == pmrc_pkg::PMRC_DPD && wake_dpd;
	assign sleep_wake = core_irq_pending;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_q <= pmrc_pkg::PMRC_ACTIVE;
		else if ((chip_rst_q || any_rst) && st_q != pmrc_pkg::PMRC_DPD)
			st_q <= pmrc_pkg::PMRC_ACTIVE;
		else begin
			case (st_q)
			pmrc_pkg::PMRC_ACTIVE: begin
				if (core_sleep_req) begin
					case (mode_sel)
					2'h0: st_q <= pmrc_pkg::PMRC_SLEEP;
					2'h1: st_q <= pmrc_pkg::PMRC_DSLEEP;
					2'h2: st_q <= pmrc_pkg::PMRC_PDOWN;
					default: st_q <= lock ? pmrc_pkg::PMRC_PDOWN : pmrc_pkg::PMRC_DPD;
					endcase
				end
			end
			pmrc_pkg::PMRC_SLEEP:
				if (sleep_wake) st_q <= pmrc_pkg::PMRC_ACTIVE;
			pmrc_pkg::PMRC_DSLEEP, pmrc_pkg::PMRC_PDOWN:
				if (wake_any) st_q <= pmrc_pkg::PMRC_ACTIVE;
			pmrc_pkg::PMRC_DPD: if (wake_dpd) st_q <= pmrc_pkg::PMRC_ACTIVE;
			default: st_q <= pmrc_pkg::PMRC_ACTIVE;
			endcase
		end
	end

	// =====================================================
	// Power and clock controls
	pmrc_pkg::pmrc_power_t pw_d;
	always_comb begin
		pw_d = '{core_clk_en: 1'b1, irc_en: 1'b1, irc_out_en: 1'b1, watchdog_osc_en: 1'b1,
			sysosc_en: 1'b1, analog_en: 1'b1, flash_on: 1'b1, flash_standby: 1'b0,
			bod_en: bod_on, chip_power: 1'b1};
		case (st_q)
		pmrc_pkg::PMRC_SLEEP: pw_d.core_clk_en = 1'b0;
		pmrc_pkg::PMRC_DSLEEP: begin
			pw_d.core_clk_en = 1'b0;
			pw_d.irc_out_en = wd_irc;
			pw_d.watchdog_osc_en = wd_osc;
			pw_d.sysosc_en = 1'b0;
			pw_d.analog_en = 1'b0;
			pw_d.flash_standby = 1'b1;
		end
		pmrc_pkg::PMRC_PDOWN: begin
			pw_d.core_clk_en = 1'b0;
			pw_d.irc_en = 1'b0;
			pw_d.irc_out_en = 1'b0;
			pw_d.watchdog_osc_en = wd_osc;
			pw_d.sysosc_en = 1'b0;
			pw_d.analog_en = 1'b0;
			pw_d.flash_on = 1'b0;
		end
		pmrc_pkg::PMRC_DPD: pw_d = '0;
		default: ;
		endcase
		if (chip_rst_q) begin
			pw_d.irc_en = 1'b1;
			pw_d.irc_out_en = 1'b1;
			pw_d.flash_on = 1'b1;
		end
	end
	logic [31:0] pclk_d;
	always_comb begin
		if (st_q == pmrc_pkg::PMRC_ACTIVE || st_q == pmrc_pkg::PMRC_SLEEP)
			pclk_d = clkgate_q;
		else
			pclk_d = 32'h0000_0000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_ctl <= '0;
			periph_clk_en <= 32'h0000_0000;
			core_reset_n <= 1'b0;
			reset_state_out <= 1'b1;
			core_boot_addr <= `PMRC_BOOT_ADDR;
			brownout_irq <= 1'b0;
			sysclk_sel_rc <= 1'b1;
		end else begin
			power_ctl <= pw_d;
			periph_clk_en <= pclk_d;
			core_reset_n <= !chip_rst_q;
			reset_state_out <= chip_rst_q;
			core_boot_addr <= `PMRC_BOOT_ADDR;
			brownout_irq <= bod_on && bod_irq_s;
			sysclk_sel_rc <= chip_rst_q || st_q == pmrc_pkg::PMRC_DPD
				|| ctrl_q[`PMRC_CTRL_SYSCLK_BIT] == 1'b0;
		end
	end

	// =====================================================
	// AXI4-Lite slave
	logic aw_hold_q, w_hold_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	assign do_write = aw_hold_q && w_hold_q && !s_bvalid;
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction : merge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'h0;
		end else begin
			s_awready <= !aw_hold_q && !s_awready && s_awvalid;
			s_wready <= !w_hold_q && !s_wready && s_wvalid;
			if (s_awvalid && s_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (awaddr_q == `PMRC_OFS_CTRL || awaddr_q == `PMRC_OFS_CLKGATE
					|| awaddr_q == `PMRC_OFS_WAKEEN) ? 2'h0 : 2'h2;
			end else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end
	// Chip reset returns control to defaults so the core restarts cleanly
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `PMRC_CTRL_RST;
			clkgate_q <= `PMRC_CLKGATE_RST;
			wakeen_q <= `PMRC_WAKEEN_RST;
		end else if (chip_rst_q) begin
			ctrl_q <= `PMRC_CTRL_RST;
			clkgate_q <= `PMRC_CLKGATE_RST;
			wakeen_q <= `PMRC_WAKEEN_RST;
		end else if (do_write) begin
			if (awaddr_q == `PMRC_OFS_CTRL) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			if (awaddr_q == `PMRC_OFS_CLKGATE)
				clkgate_q <= merge(clkgate_q, wdata_q, wstrb_q);
			if (awaddr_q == `PMRC_OFS_WAKEEN) wakeen_q <= merge(wakeen_q, wdata_q, wstrb_q);
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= 2'h0;
		end else begin
			s_arready <= !s_arready && !s_rvalid && s_arvalid;
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp <= 2'h0;
				case (s_araddr)
				`PMRC_OFS_CTRL: s_rdata <= ctrl_q;
				`PMRC_OFS_CLKGATE: s_rdata <= clkgate_q;
				`PMRC_OFS_WAKEEN: s_rdata <= wakeen_q;
				`PMRC_OFS_STATUS: s_rdata <= {24'h0, bod_irq_s, bod_lvl_s, 2'h0, st_q};
				`PMRC_OFS_BOOT: s_rdata <= `PMRC_BOOT_ADDR;
				default: begin
					s_rdata <= 32'h0000_0000;
					s_rresp <= 2'h2;
				end
				endcase
			end else if (s_rvalid && s_rready)
				s_rvalid <= 1'b0;
		end
	end

	// =====================================================
	// Assertions
	a_sleep_gates_core: assert property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_SLEEP |=> !power_ctl.core_clk_en)
		else $error("core clock running in sleep");
	a_dpd_lock_blocks: assert property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_ACTIVE && core_sleep_req && lock && !chip_rst_q
		|=> st_q != pmrc_pkg::PMRC_DPD)
		else $error("deep power-down entered while locked");
	a_rst_status_pin: assert property (@(posedge clk) disable iff (rst)
		reset_state_out == !core_reset_n)
		else $error("reset status disagrees with core reset");
	a_dsleep_no_pclk: assert property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_DSLEEP |=> periph_clk_en == 32'h0)
		else $error("peripheral clock in deep sleep");
	a_wdt_resets: assert property (@(posedge clk) disable iff (rst)
		wdt_reset |=> ##1 !core_reset_n)
		else $error("watchdog reset not applied");
	a_pin_ignored_dpd: assert property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_DPD |-> !pin_rst)
		else $error("reset pin active in deep power-down");
	a_boot_zero: assert property (@(posedge clk) disable iff (rst)
		$rose(core_reset_n) |-> core_boot_addr == 32'h0)
		else $error("boot address not zero");
	a_pd_flash_off: assert property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_PDOWN && !chip_rst_q |=> !power_ctl.flash_on)
		else $error("flash on in power-down");
	c_sleep_wake: cover property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_SLEEP ##1 st_q == pmrc_pkg::PMRC_ACTIVE);
	c_dpd_wake: cover property (@(posedge clk) disable iff (rst)
		st_q == pmrc_pkg::PMRC_DPD ##1 st_q == pmrc_pkg::PMRC_ACTIVE);
	c_pin_reset: cover property (@(posedge clk) disable iff (rst) $rose(pin_rst));
endmodule : pmrc_top
`default_nettype wire

// *** verif/pmrc_core_model.sv ***
// Core-side partner: sleep requester and wake-pin driver
`default_nettype none
module pmrc_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench commands
	input wire logic go,
	input wire logic pull_wake,
	// Block outputs seen by the core
	input wire logic core_clk_en,
	input wire logic core_reset_n,
	// Requests
	output logic core_sleep_req,
	output logic deep_wake_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// ========
	// Sleep request
	// Dropped once the clock stops, so a woken core does not fall asleep again
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_sleep_req <= 1'b0;
		end else if (!core_reset_n || !core_clk_en) begin
			core_sleep_req <= 1'b0;
		end else if (go) begin
			core_sleep_req <= 1'b1;
		end
	end
	// Pull-up holds the pin high; driven low only to wake
	assign deep_wake_pin = !pull_wake;
endmodule : pmrc_core_model
`default_nettype wire

// *** verif/power_mode_reset_control_test.sv ***
// Self-checking bench for the power-mode and reset controller
`include "pmrc_consts.svh"
`default_nettype none
module power_mode_reset_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, pclk, boot;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, sreq, wpin, crst, birq, rcsel, rso;
	logic [1:0] bresp, rresp, lvl = '0;
	logic go = 0, pull = 0, irq = 0, rpin = 1, wdt = 0, por = 1, bodi = 0, rtcw = 0;
	logic [3:0] uok = '0;
	pmrc_pkg::pmrc_wake_t wk = '0;
	pmrc_pkg::pmrc_power_t pc;
	int mismatches = 0, n_tests = 0, i, k;
	logic [31:0] seed = 32'h0000_000c;

	always #10 clk = ~clk;

	pmrc_top uut (.clk(clk), .rst(rst), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .core_sleep_req(sreq),
		.core_irq_pending(irq), .core_reset_n(crst), .core_boot_addr(boot),
		.brownout_irq(birq), .reset_pin_n(rpin), .deep_wake_pin(wpin), .wdt_reset(wdt),
		.por_n(por), .bod_below_irq(bodi), .bod_below_rst(1'b0), .bod_below_lvl(lvl),
		.wake_in(wk), .uart_wake_ok(uok), .rtc_wake(rtcw), .periph_clk_en(pclk),
		.power_ctl(pc), .sysclk_sel_rc(rcsel), .reset_state_out(rso));

	pmrc_core_model cm (.clk(clk), .rst(rst), .go(go), .pull_wake(pull),
		.core_clk_en(pc.core_clk_en), .core_reset_n(crst), .core_sleep_req(sreq),
		.deep_wake_pin(wpin));

	// ========
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	task automatic conclude();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// A wait that ran out ends the run
	task automatic need(input string nm, input logic got, input logic exp);
		chk(nm, {31'h0, got}, {31'h0, exp});
		if (got !== exp) begin
			conclude();
		end
	endtask : need

	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int j = 0; j < 50; j++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		need("bvalid", bvalid, 1'b1);
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
		@(posedge clk);
	endtask : axw

	task automatic axr(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int j = 0; j < 50; j++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		need("rvalid", rvalid, 1'b1);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		if (er == 2'h0) chk("rdata", rdata, exp);
		rready <= 1'b0;
		@(posedge clk);
	endtask : axr

	// Core asks for the mode held in the control word
	task automatic enter();
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 40 && pc.core_clk_en !== 1'b0; i++) @(posedge clk);
		need("core clock off", pc.core_clk_en, 1'b0);
		repeat (3) @(posedge clk);
	endtask : enter

	task automatic woken(input string nm);
		for (i = 0; i < 60 && pc.core_clk_en !== 1'b1; i++) @(posedge clk);
		need(nm, pc.core_clk_en, 1'b1);
	endtask : woken

	// ========
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
		chk("rst state", {rso, crst, rcsel}, 3'b011);
		chk("boot addr", boot, 32'h0);
		axr(`PMRC_OFS_CTRL, 32'h0000_0020, 2'h0);
		axr(`PMRC_OFS_CLKGATE, 32'hffff_ffff, 2'h0);
		axr(`PMRC_OFS_WAKEEN, 32'h0, 2'h0);
		axr(`PMRC_OFS_STATUS, 32'h0, 2'h0);
		axr(`PMRC_OFS_BOOT, 32'h0, 2'h0);
		axr(12'h014, 32'h0, 2'h2);
		axw(`PMRC_OFS_STATUS, 32'h1, 2'h2);
		axw(`PMRC_OFS_BOOT, 32'h4, 2'h2);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			axw(`PMRC_OFS_CLKGATE, seed, 2'h0);
			chk("periph gates", pclk, seed);
		end
		axw(`PMRC_OFS_WAKEEN, 32'h0000_7fff, 2'h0);
		axw(`PMRC_OFS_CTRL, 32'h0000_0020, 2'h0);
		enter();
		chk("sleep periph", pclk, seed);
		irq <= 1'b1;
		woken("sleep wake");
		irq <= 1'b0;
		axw(`PMRC_OFS_CTRL, 32'h0000_0021, 2'h0);
		enter();
		chk("deep-sleep", {pclk[0], pc.irc_en, pc.irc_out_en, pc.sysosc_en, pc.analog_en,
			pc.flash_standby, pc.bod_en}, 7'b0100011);
		chk("deep-sleep gates", pclk, 32'h0);
		irq <= 1'b1;
		wk.uart[0] <= 1'b1;
		repeat (8) @(posedge clk);
		chk("unqualified uart", pc.core_clk_en, 1'b0);
		uok[0] <= 1'b1;
		woken("uart wake");
		irq <= 1'b0;
		wk <= '0;
		uok <= '0;
		axw(`PMRC_OFS_CTRL, 32'h0000_0032, 2'h0);
		enter();
		chk("power-down", {pclk[0], pc.irc_en, pc.watchdog_osc_en, pc.analog_en, pc.flash_on,
			pc.bod_en, pc.sysosc_en}, 7'b0010010);
		seed = xs(seed);
		wk.gpio[seed[2:0]] <= 1'b1;
		woken("gpio wake");
		wk <= '0;
		axw(`PMRC_OFS_CTRL, 32'h0000_0007, 2'h0);
		enter();
		chk("locked", {pc.chip_power, pc.flash_on}, 2'b10);
		wk.rtc <= 1'b1;
		woken("rtc wake");
		wk <= '0;
		for (k = 0; k < 2; k++) begin
			axw(`PMRC_OFS_CTRL, 32'h0000_0103, 2'h0);
			chk("sysclk moved", rcsel, 1'b0);
			enter();
			rpin <= (k == 1);
			repeat (6) @(posedge clk);
			rpin <= 1'b1;
			repeat (8) @(posedge clk);
			chk("deep power-down", pc.chip_power, 1'b0);
			if (k == 0) pull <= 1'b1;
			else rtcw <= 1'b1;
			for (i = 0; i < 60 && crst !== 1'b0; i++) @(posedge clk);
			need("dpd reset", crst, 1'b0);
			pull <= 1'b0;
			rtcw <= 1'b0;
			for (i = 0; i < 60 && crst !== 1'b1; i++) @(posedge clk);
			need("dpd wake", crst, 1'b1);
			chk("sysclk back", {pc.chip_power, rcsel}, 2'b11);
			repeat (4) @(posedge clk);
		end
		for (k = 0; k < 4; k++) begin
			axw(`PMRC_OFS_CLKGATE, 32'h0, 2'h0);
			if (k == 0) enter();
			if (k == 3) begin
				axw(`PMRC_OFS_CTRL, 32'h0000_0060, 2'h0);
				lvl <= 2'b10;
				repeat (8) @(posedge clk);
				chk("other level", crst, 1'b1);
			end
			case (k)
				0: rpin <= 1'b0;
				1: wdt <= 1'b1;
				2: por <= 1'b0;
				default: lvl <= 2'b01;
			endcase
			repeat (3) @(posedge clk);
			rpin <= 1'b1;
			wdt <= 1'b0;
			por <= 1'b1;
			lvl <= 2'b00;
			for (i = 0; i < 20 && crst !== 1'b0; i++) @(posedge clk);
			need("chip reset", crst, 1'b0);
			chk("reset out", rso, 1'b1);
			for (i = 0; i < 60 && crst !== 1'b1; i++) @(posedge clk);
			need("reset end", crst, 1'b1);
			chk("awake", {rso, pc.core_clk_en, pc.irc_en}, 3'b011);
			repeat (4) @(posedge clk);
			axr(`PMRC_OFS_CLKGATE, 32'hffff_ffff, 2'h0);
		end
		bodi <= 1'b1;
		for (i = 0; i < 10 && birq !== 1'b1; i++) @(posedge clk);
		need("brownout irq", birq, 1'b1);
		axr(`PMRC_OFS_STATUS, 32'h0000_0080, 2'h0);
		bodi <= 1'b0;
		conclude();
	end

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		conclude();
	end
endmodule : power_mode_reset_control_test
`default_nettype wire
